// ---- dv/tb.sv ----
/*
  Self-checking bench for test_mode_control: mode table, clock sources,
  PLL steering, column monitor, bus mirroring and port E.
  Assumes tester_model drives crystal pins and port A.
*/
`timescale 1ns/100ps
module tb;
  typedef struct packed {logic a, b, lvl, dbg, hiz, frz, byp;} row_t;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pin_a = 1'b1, pin_b = 1'b1, user_lvl = 1'b1, por_n = 1'b0, sweep = 1'b0;
  logic main_xtal, rtc_xtal, prev;
  logic [7:0] port_a, col;
  logic [7:0] col_func = 8'h5a;
  test_mode_pkg::clk_mon_t clk_mon = 5'h15;
  logic [31:0] sysctl = 32'h0;
  logic p_acc = 1'b0, p_wr = 1'b0, e_acc = 1'b0, e_wr = 1'b0;
  logic [27:0] p_addr = 28'h0, e_addr = 28'h0, addr_o;
  logic [31:0] p_data = 32'h0, e_data = 32'h0, data_o;
  test_mode_pkg::cpu_mon_t cpu_mon = 3'h5;
  logic [2:0] pe_func = 3'h2, pe;
  logic main_src, rtc_src, freeze, dbg, hiz, wr_o, cs5_n, ripple;
  test_mode_pkg::pll_ctl_t pll;
  wire main_osc = ~main_xtal;
  wire rtc_osc = ~rtc_xtal;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  row_t r;
  // Normal, normal, bypass, bypass, oscillator test, undefined as normal, debug, high impedance
  row_t rows [8] = '{7'h70, 7'h60, 7'h41, 7'h51, 7'h22, 7'h30, 7'h18, 7'h04};

  always #12.5 ref_clk_i = ~ref_clk_i;

  tester_model i_tester (.sweep_i(sweep), .main_crystal_o(main_xtal),
    .rtc_crystal_o(rtc_xtal), .port_a_o(port_a));

  test_mode_control i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .test_select_pin_a_i(pin_a), .test_select_pin_b_i(pin_b),
    .user_reset_level_i(user_lvl), .power_on_reset_n_i(por_n),
    .main_crystal_input_i(main_xtal), .rtc_crystal_input_i(rtc_xtal),
    .main_osc_clk_i(main_osc), .rtc_osc_clk_i(rtc_osc), .main_clk_src_o(main_src),
    .rtc_clk_src_o(rtc_src), .pll_ctl_o(pll), .port_a_bits_i(port_a),
    .col_func_i(col_func), .clk_mon_i(clk_mon), .col_o(col), .logic_freeze_o(freeze),
    .debug_enable_o(dbg), .output_hiz_o(hiz), .system_control_reg_i(sysctl),
    .periph_access_i(p_acc), .periph_write_i(p_wr), .periph_addr_i(p_addr),
    .periph_data_i(p_data), .ext_cs5_access_i(e_acc), .ext_addr_i(e_addr),
    .ext_data_i(e_data), .ext_write_i(e_wr), .bus_addr_o(addr_o), .bus_data_o(data_o),
    .bus_write_o(wr_o), .chip_select_five_n_o(cs5_n), .cpu_mon_i(cpu_mon),
    .port_e_func_i(pe_func), .port_e_bits_o(pe), .ripple_div_o(ripple));

  task automatic step(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // Latch a level at the power-on rise, then move the pin away again
  task automatic latch_level(input logic v);
    por_n = 1'b0;
    user_lvl = v;
    step(4);
    por_n = 1'b1;
    step(4);
    user_lvl = ~v;
  endtask

  task automatic check_src(input logic byp);
    @(main_xtal);
    #1;
    check(main_src === (byp ? main_xtal : main_osc), "main clock source");
    @(rtc_xtal);
    #1;
    check(rtc_src === (byp ? rtc_xtal : rtc_osc), "rtc clock source");
    @(negedge ref_clk_i);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cut a hang short well past the expected run length
  initial
  begin
    #2000000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    step(16);
    arst_n_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      latch_level(r.lvl);
      pin_a = r.a;
      pin_b = r.b;
      step(6);
      check(dbg === r.dbg && hiz === r.hiz && freeze === r.frz,
        "mode outputs");
      check(pll.osc_disable_all === r.byp, "oscillator disable");
      check_src(r.byp);
      $display("mode row %0d done", i);
    end
    latch_level(1'b0);
    pin_a = 1'b1;
    pin_b = 1'b1;
    step(6);
    check(col === col_func && pll === 7'h74, "normal pins");
    pin_a = 1'b0;
    step(6);
    check(pll === 7'h74, "zero port defaults");
    check({col[6], col[4], col[2], col[1], col[0]} === {clk_mon.pll_test,
      clk_mon.ripple_div, clk_mon.main_div, clk_mon.one_hz, clk_mon.rtc_osc},
      "column clocks");
    // Not symmetric, so a reversed column order shows
    clk_mon = 5'h0c;
    sweep = 1'b1;
    step(6);
    check(pll === 7'h06, "inverted port controls");
    check({col[6], col[4], col[2], col[1], col[0]} === 5'h06, "column clocks moved");
    sweep = 1'b0;
    n = 0;
    for (int k = 0; k < 128; k++)
    begin
      prev = ripple;
      step(1);
      if (ripple !== prev)
        n++;
    end
    check(n == 4, "ripple divider rate");
    $display("oscillator test done");
    pin_a = 1'b1;
    step(6);
    #2;
    pin_a = 1'b0;
    pin_b = 1'b0;
    #1;
    check(hiz === 1'b1, "high impedance without a clock edge");
    step(1);
    pin_a = 1'b1;
    pin_b = 1'b1;
    step(6);
    check(hiz === 1'b0 && dbg === 1'b0 && pll === 7'h74 && col === col_func,
      "left high impedance");
    $display("high impedance test done");
    // No display DMA exists here, so mirroring is safe to enable
    e_acc = 1'b1;
    e_addr = 28'h0000123;
    e_wr = 1'b1;
    step(1);
    e_acc = 1'b0;
    check(cs5_n === 1'b0 && addr_o === 28'h0000123 && pe === pe_func, "plain cs5");
    sysctl = 32'h00000800;
    for (int k = 0; k < 2; k++)
    begin
      p_acc = 1'b1;
      p_wr = k[0];
      p_addr = 28'h0000440 + 28'(k);
      p_data = 32'ha5c30000 + 32'(k);
      // First access mirrored alone, second beside an own-range access
      e_acc = k[0];
      step(1);
      check(cs5_n === 1'b0 && addr_o === p_addr && data_o === p_data &&
        wr_o === p_wr, "mirrored access");
    end
    p_acc = 1'b0;
    e_acc = 1'b0;
    step(1);
    check(cs5_n === 1'b1, "cs5 idle");
    for (int k = 0; k < 2; k++)
    begin
      cpu_mon = k[0] ? 3'h3 : 3'h4;
      step(2);
      check(pe === (k[0] ? 3'h6 : 3'h1), "port e cpu signals");
    end
    $display("mirror test done");
    arst_n_i = 1'b0;
    step(1);
    check(pll === 7'h74 && cs5_n === 1'b1 && pe === 3'h0 && dbg === 1'b0, "reset");
    arst_n_i = 1'b1;
    $display("reset test done");
    finish_test();
  end
endmodule // tb

// ---- dv/tester_model.sv ----
/*
  Tester model: drives the crystal pins at the bypass rates and the
  port A control pattern. Assumes the bench commands any PLL sweep.
*/
`timescale 1ns/100ps
module tester_model (
  // Bench command
  input  wire logic       sweep_i,
  // Pins toward the device
  output logic            main_crystal_o,
  output logic            rtc_crystal_o,
  output logic [7:0]      port_a_o
);
  initial main_crystal_o = 1'b0;
  initial rtc_crystal_o = 1'b0;
  always #13.6 main_crystal_o = ~main_crystal_o;
  always #15258.8 rtc_crystal_o = ~rtc_crystal_o;
  assign port_a_o = sweep_i ? 8'hff : 8'h00;
endmodule // tester_model

// ---- hw/mode_latch.sv ----
/*
  Captures the user-reset level at the rising edge of power-on reset and
  decodes the test mode from the synchronised test pins.
  Assumes test pins and reset levels arrive from pins on any timing.
*/
`timescale 1ns/100ps
module mode_latch (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   arst_n_i,
  // Pins
  input  wire logic                   test_select_pin_a_i,
  input  wire logic                   test_select_pin_b_i,
  input  wire logic                   user_reset_level_i,
  input  wire logic                   power_on_reset_n_i,
  // Decoded mode
  output test_mode_pkg::test_mode_t   mode_o,
  output logic                        hiz_async_o,
  output logic                        latched_reset_o
);

  logic [1:0] a_sync_reg, a_sync_next;
  logic [1:0] b_sync_reg, b_sync_next;
  logic [1:0] u_sync_reg, u_sync_next;
  logic [1:0] p_sync_reg, p_sync_next;
  logic       latched_reg, latched_next;
  logic       por_dly_reg, por_dly_next;
  test_mode_pkg::test_mode_t mode_reg, mode_next;

  always_comb
  begin
    a_sync_next  = {a_sync_reg[0], test_select_pin_a_i};
    b_sync_next  = {b_sync_reg[0], test_select_pin_b_i};
    u_sync_next  = {u_sync_reg[0], user_reset_level_i};
    p_sync_next  = {p_sync_reg[0], power_on_reset_n_i};
    por_dly_next = p_sync_reg[1];
    latched_next = latched_reg;
    // follow while low, hold after rise
    if (!p_sync_reg[1])
    begin
      latched_next = u_sync_reg[1];
    end
    case ({a_sync_reg[1], b_sync_reg[1]})
      2'b10:   mode_next = test_mode_pkg::MODE_BYPASS;
      2'b01:   mode_next = latched_reg ? test_mode_pkg::MODE_NORMAL
                                       : test_mode_pkg::MODE_OSC_TEST;
      2'b00:   mode_next = latched_reg ? test_mode_pkg::MODE_DEBUG
                                       : test_mode_pkg::MODE_HIZ;
      default: mode_next = test_mode_pkg::MODE_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      a_sync_reg  <= 2'h3;
      b_sync_reg  <= 2'h3;
      u_sync_reg  <= 2'h0;
      p_sync_reg  <= 2'h0;
      por_dly_reg <= 1'b0;
      latched_reg <= test_mode_pkg::LATCH_RESET;
      mode_reg    <= test_mode_pkg::MODE_NORMAL;
    end
    else
    begin
      a_sync_reg  <= a_sync_next;
      b_sync_reg  <= b_sync_next;
      u_sync_reg  <= u_sync_next;
      p_sync_reg  <= p_sync_next;
      por_dly_reg <= por_dly_next;
      latched_reg <= latched_next;
      mode_reg    <= mode_next;
    end
  end

  // asynchronous hi-z straight from the pins
  assign hiz_async_o     = !test_select_pin_a_i && !test_select_pin_b_i && !latched_reg;
  assign mode_o          = mode_reg;
  assign latched_reset_o = latched_reg;

  // latch frozen once reset is high
  property p_latch_hold;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (p_sync_reg[1] && por_dly_reg) |=> $stable(latched_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("user reset latch changed after power-on reset rose");

  property p_bypass_decode;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (a_sync_reg[1] && !b_sync_reg[1]) |=> (mode_reg == test_mode_pkg::MODE_BYPASS);
  endproperty
  a_bypass_decode: assert property (p_bypass_decode)
    else $error("bypass mode not decoded");

  property p_normal_decode;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (a_sync_reg[1] && b_sync_reg[1]) |=> (mode_reg == test_mode_pkg::MODE_NORMAL);
  endproperty
  a_normal_decode: assert property (p_normal_decode)
    else $error("both pins high not normal");

  property p_test_decode;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (!a_sync_reg[1] && b_sync_reg[1] && !latched_reg)
        |=> (mode_reg == test_mode_pkg::MODE_OSC_TEST);
  endproperty
  a_test_decode: assert property (p_test_decode)
    else $error("oscillator test mode not decoded");

  property p_debug_decode;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (!a_sync_reg[1] && !b_sync_reg[1] && latched_reg)
        |=> (mode_reg == test_mode_pkg::MODE_DEBUG);
  endproperty
  a_debug_decode: assert property (p_debug_decode)
    else $error("debug mode not decoded");

endmodule // mode_latch

// ---- hw/test_mode_control.sv ----
/*
  Test-mode control: decodes the hardware test modes, steers PLL controls
  from port A, monitors clocks on the column pins, forces outputs to high
  impedance, and mirrors peripheral-bus accesses with CPU signals on port E.
  Assumes clocks to be monitored arrive as plain levels from the clock tree
  and the peripheral bus signals are on ref_clk_i.
*/
// What this block does
// - Bypass mode disables oscillators, crystals feed clocks
// - Oscillator test mode enables main oscillator
// - Test mode freezes logic except ripple, RTC
// - Port A bits drive PLL controls in oscillator test mode
// - Column pins output five monitored clocks in oscillator test mode
// - Port A inverted except the bypass bit, so zeros give defaults
// - Debug mode enabled only in its mode
// - Hi-z mode floats every output asynchronously
// - Hi-z entry leaves internal state untouched
// - Mirror bit copies peripheral accesses outside
// - Chip select five covers mirrored and own
// - Port E shows clock and interrupts
// - Shown clock is the gated CPU clock, sampled on ref_clk_i
// - Interrupt outputs are controller requests
// - Reset level latched at power-on rise
`timescale 1ns/100ps
module test_mode_control #(
  parameter int unsigned ADDR_W = 28,
  parameter int unsigned DATA_W = 32
) (
  // Clock and reset
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   arst_n_i,
  // Mode pins
  input  wire logic                                   test_select_pin_a_i,
  input  wire logic                                   test_select_pin_b_i,
  input  wire logic                                   user_reset_level_i,
  input  wire logic                                   power_on_reset_n_i,
  // Crystal pins and oscillator outputs
  input  wire logic                                   main_crystal_input_i,
  input  wire logic                                   rtc_crystal_input_i,
  input  wire logic                                   main_osc_clk_i,
  input  wire logic                                   rtc_osc_clk_i,
  output logic                                        main_clk_src_o,
  output logic                                        rtc_clk_src_o,
  // PLL controls
  output test_mode_pkg::pll_ctl_t                     pll_ctl_o,
  // Port A and column pins
  input  wire logic [test_mode_pkg::PORT_A_W-1:0]     port_a_bits_i,
  input  wire logic [test_mode_pkg::COL_W-1:0]        col_func_i,
  input  wire test_mode_pkg::clk_mon_t                clk_mon_i,
  output logic      [test_mode_pkg::COL_W-1:0]        col_o,
  // Internal logic freeze and debug
  output logic                                        logic_freeze_o,
  output logic                                        debug_enable_o,
  output logic                                        output_hiz_o,
  // System control and peripheral bus
  input  wire logic [test_mode_pkg::SYSCTL_W-1:0]     system_control_reg_i,
  input  wire logic                                   periph_access_i,
  input  wire logic                                   periph_write_i,
  input  wire logic [ADDR_W-1:0]                      periph_addr_i,
  input  wire logic [DATA_W-1:0]                      periph_data_i,
  input  wire logic                                   ext_cs5_access_i,
  input  wire logic [ADDR_W-1:0]                      ext_addr_i,
  input  wire logic [DATA_W-1:0]                      ext_data_i,
  input  wire logic                                   ext_write_i,
  output logic      [ADDR_W-1:0]                      bus_addr_o,
  output logic      [DATA_W-1:0]                      bus_data_o,
  output logic                                        bus_write_o,
  output logic                                        chip_select_five_n_o,
  // Port E
  input  wire test_mode_pkg::cpu_mon_t                cpu_mon_i,
  input  wire logic [test_mode_pkg::PORT_E_W-1:0]     port_e_func_i,
  output logic      [test_mode_pkg::PORT_E_W-1:0]     port_e_bits_o,
  // Ripple counter output
  output logic                                        ripple_div_o
);

  test_mode_pkg::test_mode_t mode;
  logic                      hiz_async;
  logic                      latched_reset;

  mode_latch u_mode_latch (
    .ref_clk_i           (ref_clk_i),
    .arst_n_i            (arst_n_i),
    .test_select_pin_a_i (test_select_pin_a_i),
    .test_select_pin_b_i (test_select_pin_b_i),
    .user_reset_level_i  (user_reset_level_i),
    .power_on_reset_n_i  (power_on_reset_n_i),
    .mode_o              (mode),
    .hiz_async_o         (hiz_async),
    .latched_reset_o     (latched_reset)
  );

  logic       osc_test;
  logic       mirror_en;
  logic [test_mode_pkg::PORT_A_W-1:0] pa_s1_reg, pa_s2_reg;
  logic [test_mode_pkg::PORT_A_W-1:0] pa_s1_next, pa_s2_next;
  logic [test_mode_pkg::RIPPLE_W-1:0] ripple_reg, ripple_next;
  test_mode_pkg::pll_ctl_t            pll_reg, pll_next;
  logic [test_mode_pkg::COL_W-1:0]    col_reg, col_next;
  logic [test_mode_pkg::PORT_E_W-1:0] pe_reg, pe_next;
  logic [ADDR_W-1:0]                  addr_reg, addr_next;
  logic [DATA_W-1:0]                  data_reg, data_next;
  logic                               wr_reg, wr_next;
  logic                               cs5_reg, cs5_next;

  assign osc_test  = (mode == test_mode_pkg::MODE_OSC_TEST);
  assign mirror_en = system_control_reg_i[test_mode_pkg::SYSCTL_MIRROR_BIT];

  // Port A, ripple counter, PLL controls, column and bus mirror
  always_comb
  begin
    pa_s1_next  = port_a_bits_i;
    pa_s2_next  = pa_s1_reg;
    ripple_next = ripple_reg + 6'h01;
    pll_next    = pll_reg;
    pll_next.test_select     = ~pa_s2_reg[test_mode_pkg::PA_PLL_TEST_SELECT_BIT];
    pll_next.osc_enable      = ~pa_s2_reg[test_mode_pkg::PA_XTL_BIT];
    pll_next.pll_enable      = ~pa_s2_reg[test_mode_pkg::PA_PLL_ENABLE_BIT];
    pll_next.bypass          = ~pa_s2_reg[test_mode_pkg::PA_BYPASS_BIT];
    pll_next.bypass          = ~pll_next.bypass;
    pll_next.div_ctl_0       = test_mode_pkg::PLL_D0_DEFAULT;
    pll_next.div_ctl_1       = test_mode_pkg::PLL_D1_DEFAULT;
    pll_next.osc_disable_all = 1'b0;
    // port A steers PLL only in test mode
    if (!osc_test)
    begin
      pll_next.test_select = 1'b1;
      pll_next.osc_enable  = 1'b1;
      pll_next.pll_enable  = 1'b1;
      pll_next.bypass      = 1'b0;
    end
    // main oscillator enabled in test mode
    if (osc_test)
    begin
      pll_next.osc_disable_all = 1'b0;
    end
    if (mode == test_mode_pkg::MODE_BYPASS)
    begin
      pll_next.osc_enable      = 1'b0;
      pll_next.pll_enable      = 1'b0;
      pll_next.bypass          = 1'b1;
      pll_next.osc_disable_all = 1'b1;
    end
    col_next = col_func_i;
    if (osc_test)
    begin
      col_next[test_mode_pkg::COL_RTC_BIT]    = clk_mon_i.rtc_osc;
      col_next[test_mode_pkg::COL_1HZ_BIT]    = clk_mon_i.one_hz;
      col_next[test_mode_pkg::COL_MAIN_BIT]   = clk_mon_i.main_div;
      col_next[test_mode_pkg::COL_RIPPLE_BIT] = clk_mon_i.ripple_div;
      col_next[test_mode_pkg::COL_TEST_BIT]   = clk_mon_i.pll_test;
    end
    pe_next = port_e_func_i;
    if (mirror_en)
    begin
      pe_next[test_mode_pkg::PE_CLK_BIT] = cpu_mon_i.gated_cpu_clk;
      pe_next[test_mode_pkg::PE_FIQ_BIT] = cpu_mon_i.fast_int_request;
      pe_next[test_mode_pkg::PE_IRQ_BIT] = cpu_mon_i.normal_int_request;
    end
    addr_next = ext_addr_i;
    data_next = ext_data_i;
    wr_next   = ext_write_i;
    cs5_next  = ext_cs5_access_i;
    if (mirror_en && periph_access_i)
    begin
      addr_next = periph_addr_i;
      data_next = periph_data_i;
      wr_next   = periph_write_i;
      cs5_next  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pa_s1_reg  <= '0;
      pa_s2_reg  <= '0;
      ripple_reg <= test_mode_pkg::RIPPLE_RESET;
      pll_reg    <= '{test_select: 1'b1, osc_enable: 1'b1, pll_enable: 1'b1,
                      div_ctl_0: 1'b0, div_ctl_1: 1'b1, bypass: 1'b0,
                      osc_disable_all: 1'b0};
      col_reg    <= '0;
      pe_reg     <= '0;
      addr_reg   <= '0;
      data_reg   <= '0;
      wr_reg     <= 1'b0;
      cs5_reg    <= 1'b0;
    end
    else
    begin
      pa_s1_reg  <= pa_s1_next;
      pa_s2_reg  <= pa_s2_next;
      ripple_reg <= ripple_next;
      pll_reg    <= pll_next;
      col_reg    <= col_next;
      pe_reg     <= pe_next;
      addr_reg   <= addr_next;
      data_reg   <= data_next;
      wr_reg     <= wr_next;
      cs5_reg    <= cs5_next;
    end
  end

  assign main_clk_src_o = pll_reg.osc_disable_all ? main_crystal_input_i : main_osc_clk_i;
  assign rtc_clk_src_o  = pll_reg.osc_disable_all ? rtc_crystal_input_i : rtc_osc_clk_i;
  assign pll_ctl_o      = pll_reg;
  assign col_o          = col_reg;
  assign logic_freeze_o = osc_test;
  // debug enabled only in its mode
  assign debug_enable_o = (mode == test_mode_pkg::MODE_DEBUG);
  // hi-z gates pins only, no state reset
  assign output_hiz_o   = hiz_async;
  assign port_e_bits_o  = pe_reg;
  assign bus_addr_o     = addr_reg;
  assign bus_data_o     = data_reg;
  assign bus_write_o    = wr_reg;
  assign chip_select_five_n_o = ~cs5_reg;
  assign ripple_div_o   = ripple_reg[test_mode_pkg::RIPPLE_W-1];

  sequence s_mirror_req;
    mirror_en && periph_access_i;
  endsequence

  property p_mirror_cs;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      s_mirror_req |=> (!chip_select_five_n_o && bus_addr_o == $past(periph_addr_i));
  endproperty
  a_mirror_cs: assert property (p_mirror_cs)
    else $error("mirrored access not on external bus");

  property p_own_cs;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      ext_cs5_access_i |=> !chip_select_five_n_o;
  endproperty
  a_own_cs: assert property (p_own_cs)
    else $error("chip select five missing for own range");

  property p_pe_irq;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      mirror_en |=> port_e_bits_o[test_mode_pkg::PE_IRQ_BIT]
                    == $past(cpu_mon_i.normal_int_request);
  endproperty
  a_pe_irq: assert property (p_pe_irq)
    else $error("port E does not show normal interrupt");

  property p_pll_default;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (osc_test && pa_s2_reg == '0) |=>
        (pll_ctl_o.test_select && pll_ctl_o.osc_enable && pll_ctl_o.pll_enable
         && !pll_ctl_o.bypass && pll_ctl_o.div_ctl_1 && !pll_ctl_o.div_ctl_0);
  endproperty
  a_pll_default: assert property (p_pll_default)
    else $error("all-zero port A does not give PLL defaults");

  property p_bypass_off;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      (mode == test_mode_pkg::MODE_BYPASS) |=> (!pll_ctl_o.pll_enable && pll_ctl_o.bypass);
  endproperty
  a_bypass_off: assert property (p_bypass_off)
    else $error("bypass mode left PLL running");

  property p_col_clocks;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      osc_test |=> (col_o[test_mode_pkg::COL_RTC_BIT] == $past(clk_mon_i.rtc_osc)
                    && col_o[test_mode_pkg::COL_TEST_BIT] == $past(clk_mon_i.pll_test));
  endproperty
  a_col_clocks: assert property (p_col_clocks)
    else $error("column pins do not show monitored clocks");

  property p_ripple_runs;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      1'b1 |=> (ripple_reg == $past(ripple_reg) + 6'h01);
  endproperty
  a_ripple_runs: assert property (p_ripple_runs)
    else $error("ripple counter stopped");

  property p_debug_latch;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      debug_enable_o |-> $past(latched_reset);
  endproperty
  a_debug_latch: assert property (p_debug_latch)
    else $error("debug enabled without latched reset level high");

  property p_pe_clk_fiq;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      mirror_en |=>
        (port_e_bits_o[test_mode_pkg::PE_CLK_BIT] == $past(cpu_mon_i.gated_cpu_clk)
         && port_e_bits_o[test_mode_pkg::PE_FIQ_BIT] == $past(cpu_mon_i.fast_int_request));
  endproperty
  a_pe_clk_fiq: assert property (p_pe_clk_fiq)
    else $error("port E does not show CPU clock and fast interrupt");

endmodule // test_mode_control

// ---- hw/test_mode_pkg.sv ----
/*
  Package for the test-mode control block: mode encoding, pin positions,
  port groupings and the capture constants.
  Assumes a single 40 MHz clock domain and nothing else.
*/
package test_mode_pkg;

  // Test modes decoded from the two test pins and the latched reset level
  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'h0,
    MODE_BYPASS   = 3'h1,
    MODE_OSC_TEST = 3'h2,
    MODE_DEBUG    = 3'h3,
    MODE_HIZ      = 3'h4
  } test_mode_t;

  // Port A bit positions feeding the PLL in oscillator test mode
  localparam int unsigned PA_PLL_TEST_SELECT_BIT   = 5;
  localparam int unsigned PA_XTL_BIT    = 4;
  localparam int unsigned PA_PLL_ENABLE_BIT  = 3;
  localparam int unsigned PA_BYPASS_BIT = 0;
  localparam int unsigned PORT_A_W      = 8;

  // Column pin positions for the monitored clocks
  localparam int unsigned COL_RTC_BIT   = 0;
  localparam int unsigned COL_1HZ_BIT   = 1;
  localparam int unsigned COL_MAIN_BIT  = 2;
  localparam int unsigned COL_RIPPLE_BIT = 4;
  localparam int unsigned COL_TEST_BIT  = 6;
  localparam int unsigned COL_W         = 8;

  // Port E bit positions for the mirrored CPU signals
  localparam int unsigned PE_CLK_BIT    = 0;
  localparam int unsigned PE_FIQ_BIT    = 1;
  localparam int unsigned PE_IRQ_BIT    = 2;
  localparam int unsigned PORT_E_W      = 3;

  // System control bit that turns on bus mirroring
  localparam int unsigned SYSCTL_MIRROR_BIT = 11;
  localparam int unsigned SYSCTL_W          = 32;

  // Ripple counter width and reset values
  localparam int unsigned RIPPLE_W      = 6;
  localparam logic [5:0]  RIPPLE_RESET  = 6'h00;
  localparam logic        LATCH_RESET   = 1'b0;
  // Default PLL divider controls with the port all zero
  localparam logic        PLL_D0_DEFAULT = 1'b0;
  localparam logic        PLL_D1_DEFAULT = 1'b1;

  // Controls delivered to the PLL and oscillators
  typedef struct packed {
    logic test_select;
    logic osc_enable;
    logic pll_enable;
    logic div_ctl_0;
    logic div_ctl_1;
    logic bypass;
    logic osc_disable_all;
  } pll_ctl_t;

  // Monitored clocks from the clock tree
  typedef struct packed {
    logic rtc_osc;
    logic one_hz;
    logic main_div;
    logic ripple_div;
    logic pll_test;
  } clk_mon_t;

  // Mirrored CPU-side signals
  typedef struct packed {
    logic gated_cpu_clk;
    logic fast_int_request;
    logic normal_int_request;
  } cpu_mon_t;

endpackage
